// file: verilog/bwp_regs.svh
// register offsets, field positions, reset values and timing figures
// included by the port design file of the byte-wide buffered port and by its testbench
`ifndef BWP_REGS_SVH
`define BWP_REGS_SVH

// ==================================================================
// register offsets
`define BWP_OFS_DATA 8'h48
`define BWP_OFS_PWM 8'h4b
`define BWP_OFS_CTL 8'h4c
`define BWP_OFS_FSEL 8'h4d
`define BWP_OFS_DRV 8'h4e
`define BWP_OFS_DIR 8'h4f

// ==================================================================
// field positions
`define BWP_TSEL_LO_LSB 0
`define BWP_TSEL_HI_LSB 4
`define BWP_PWM0_BIT 0
`define BWP_PWM1_BIT 1
`define BWP_RX_ONLY_MASK 8'h88

// ==================================================================
// reset values
`define BWP_RST_ZERO 8'h00
`define BWP_RST_DIR 8'h00
`define BWP_RST_CTL 8'h00
`define BWP_RST_SEL 2'h0

// ==================================================================
// timing
`define BWP_SYNC_STAGES 2

`endif

// file: verilog/bwp_pkg.sv
// types shared by the byte-wide buffered port
// assumes bwp_regs.svh is included alongside for the numbers
package bwp_pkg;

    typedef logic [7:0] bwp_byte_t;

    typedef enum logic [1:0] {
        BWP_SRC_HALF = 2'h0,
        BWP_SRC_TMR1 = 2'h1,
        BWP_SRC_TMR2 = 2'h2,
        BWP_SRC_TMR3 = 2'h3
    } bwp_tsel_t;

endpackage : bwp_pkg

// file: verilog/bwp_sync2.sv
// two-stage level synchroniser for a bus of pins
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module bwp_sync2 #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // levels
    input wire logic [W-1:0] lvl_in,
    output logic [W-1:0] lvl_sync
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta_reg <= '0;
            lvl_sync <= '0;
        end else begin
            meta_reg <= lvl_in;
            lvl_sync <= meta_reg;
        end
    end

endmodule : bwp_sync2

// file: verilog/bwp_load_pick.sv
// load-strobe picker for one nibble of the port
// assumes timer levels are synchronous to core_clk
`timescale 1ns/1ps
module bwp_load_pick
    import bwp_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // sources
    input wire bwp_tsel_t sel,
    input wire logic half_tick,
    input wire logic [2:0] timer_lvl,
    // strobe
    output logic load
);

    logic [2:0] prev_reg;
    logic [2:0] rise;

    // one-cycle pulse on each timer rising edge
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prev_reg <= 3'h0;
        end else begin
            prev_reg <= timer_lvl;
        end
    end

    assign rise = timer_lvl & ~prev_reg;

    always_comb begin
        case (sel)
            BWP_SRC_HALF: load = half_tick;
            BWP_SRC_TMR1: load = rise[0];
            BWP_SRC_TMR2: load = rise[1];
            BWP_SRC_TMR3: load = rise[2];
            default: load = 1'b0;
        endcase
    end

endmodule : bwp_load_pick

// file: verilog/bwp_port.sv
// byte-wide buffered i/o port: registers, load timing, pin drive
// assumes a plain register port on core_clk, pins split into in/out/oe,
// and timer, serial and pwm signals synchronous to core_clk
`timescale 1ns/1ps
`include "bwp_regs.svh"
module bwp_port
    import bwp_pkg::*;
#(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pins
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    // timer outputs
    input wire logic [2:0] timer_src,
    // serial port a
    input wire logic serial_a_transmit_data,
    input wire logic serial_a_receive_clock,
    input wire logic serial_a_transmit_clock,
    output logic serial_a_receive_data,
    output logic serial_a_rx_clock_in,
    output logic serial_a_tx_clock_in,
    // serial port b
    input wire logic serial_b_transmit_data,
    input wire logic serial_b_receive_clock,
    input wire logic serial_b_transmit_clock,
    output logic serial_b_receive_data,
    output logic serial_b_rx_clock_in,
    output logic serial_b_tx_clock_in,
    // pwm
    input wire logic alt_pwm_out_zero,
    input wire logic alt_pwm_out_one
);

    // ==============================================================
    // register file
    bwp_byte_t dir_reg;
    bwp_byte_t ctl_reg;
    bwp_byte_t fsel_reg;
    bwp_byte_t drv_reg;
    bwp_byte_t buf_reg;
    logic [1:0] pwm_reg;
    logic wr_dir;
    logic wr_ctl;
    logic wr_fsel;
    logic wr_drv;
    logic wr_data;
    logic wr_pwm;

    assign wr_dir = reg_wr && (reg_addr == `BWP_OFS_DIR);
    assign wr_ctl = reg_wr && (reg_addr == `BWP_OFS_CTL);
    assign wr_fsel = reg_wr && (reg_addr == `BWP_OFS_FSEL);
    assign wr_drv = reg_wr && (reg_addr == `BWP_OFS_DRV);
    assign wr_data = reg_wr && (reg_addr == `BWP_OFS_DATA);
    assign wr_pwm = reg_wr && (reg_addr == `BWP_OFS_PWM);

    // direction: every pin an input after reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            dir_reg <= `BWP_RST_DIR;
        end else if (wr_dir) begin
            dir_reg <= reg_wdata;
        end
    end

    // timing selects: halved clock after reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctl_reg <= `BWP_RST_CTL;
        end else if (wr_ctl) begin
            ctl_reg <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fsel_reg <= `BWP_RST_ZERO;
        end else if (wr_fsel) begin
            fsel_reg <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            drv_reg <= `BWP_RST_ZERO;
        end else if (wr_drv) begin
            drv_reg <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pwm_reg <= `BWP_RST_SEL;
        end else if (wr_pwm) begin
            pwm_reg <= reg_wdata[1:0];
        end
    end

    // write side of port_data only fills the buffer
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            buf_reg <= `BWP_RST_ZERO;
        end else if (wr_data) begin
            buf_reg <= reg_wdata;
        end
    end

    // ==============================================================
    // load timing
    logic half_reg;
    logic load_lo;
    logic load_hi;
    bwp_tsel_t tsel_lo;
    bwp_tsel_t tsel_hi;

    assign tsel_lo = bwp_tsel_t'(ctl_reg[`BWP_TSEL_LO_LSB +: 2]);
    assign tsel_hi = bwp_tsel_t'(ctl_reg[`BWP_TSEL_HI_LSB +: 2]);

    // halved peripheral clock as a tick every other cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            half_reg <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
        end
    end

    bwp_load_pick u_pick_lo (
        .core_clk(core_clk),
        .nrst(nrst),
        .sel(tsel_lo),
        .half_tick(half_reg),
        .timer_lvl(timer_src),
        .load(load_lo)
    );

    bwp_load_pick u_pick_hi (
        .core_clk(core_clk),
        .nrst(nrst),
        .sel(tsel_hi),
        .half_tick(half_reg),
        .timer_lvl(timer_src),
        .load(load_hi)
    );

    // output register, each nibble on its own strobe
    bwp_byte_t out_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            out_reg <= `BWP_RST_ZERO;
        end else begin
            if (load_lo) begin
                out_reg[3:0] <= buf_reg[3:0];
            end
            if (load_hi) begin
                out_reg[7:4] <= buf_reg[7:4];
            end
        end
    end

    // ==============================================================
    // pin drive
    bwp_byte_t alt_val;
    bwp_byte_t alt_en;
    bwp_byte_t drive_val;
    bwp_byte_t out_en;
    bwp_byte_t pin_out_next;
    bwp_byte_t pin_oe_next;

    // serial and pwm sources per pin
    assign alt_val = {alt_pwm_out_one, serial_a_transmit_data,
                      serial_a_receive_clock, serial_a_transmit_clock,
                      alt_pwm_out_zero, serial_b_transmit_data,
                      serial_b_receive_clock, serial_b_transmit_clock};

    always_comb begin
        alt_en = fsel_reg & ~`BWP_RX_ONLY_MASK;
        alt_en[7] = pwm_reg[`BWP_PWM1_BIT];
        alt_en[3] = pwm_reg[`BWP_PWM0_BIT];
    end

    assign drive_val = (alt_en & alt_val) | (~alt_en & out_reg);
    // receive-data function forces the pin to listen
    assign out_en = dir_reg & ~(fsel_reg & `BWP_RX_ONLY_MASK);
    // open-drain pins only ever pull low
    assign pin_out_next = drive_val & ~drv_reg;
    assign pin_oe_next = out_en & (~drv_reg | ~drive_val);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pin_out <= `BWP_RST_ZERO;
            pin_oe <= `BWP_RST_ZERO;
        end else begin
            pin_out <= pin_out_next;
            pin_oe <= pin_oe_next;
        end
    end

    // ==============================================================
    // pin sampling
    bwp_byte_t pin_sync;

    bwp_sync2 #(.W(PINS)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .lvl_in(pin_in),
        .lvl_sync(pin_sync)
    );

    assign serial_a_receive_data = pin_sync[7];
    assign serial_a_rx_clock_in = pin_sync[5];
    assign serial_a_tx_clock_in = pin_sync[4];
    assign serial_b_receive_data = pin_sync[3];
    assign serial_b_rx_clock_in = pin_sync[1];
    assign serial_b_tx_clock_in = pin_sync[0];

    // ==============================================================
    // read side
    bwp_byte_t port_view;
    bwp_byte_t rdata_next;

    // outputs read back their driven value, inputs the pin
    assign port_view = (out_en & drive_val) | (~out_en & pin_sync);

    always_comb begin
        case (reg_addr)
            `BWP_OFS_DATA: rdata_next = port_view;
            `BWP_OFS_PWM: rdata_next = {6'h00, pwm_reg};
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ==============================================================
    // checks
    chk_reset_clear: assert property (@(posedge core_clk)
        !nrst |=> (dir_reg == 8'h00) && (ctl_reg[5:4] == 2'h0)
                  && (ctl_reg[1:0] == 2'h0))
        else $error("reset left direction or selects set");

    chk_dir_write: assert property (@(posedge core_clk)
        disable iff (!nrst)
        wr_dir |=> dir_reg == $past(reg_wdata))
        else $error("direction write lost");

    chk_out_hold_lo: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && !load_lo |=> out_reg[3:0] == $past(out_reg[3:0]))
        else $error("low nibble moved without strobe");

    chk_load_lo: assert property (@(posedge core_clk)
        disable iff (!nrst)
        load_lo |=> out_reg[3:0] == $past(buf_reg[3:0]))
        else $error("low nibble not loaded");

    chk_load_hi: assert property (@(posedge core_clk)
        disable iff (!nrst)
        load_hi |=> out_reg[7:4] == $past(buf_reg[7:4]))
        else $error("high nibble not loaded");

    chk_out_hold_hi: assert property (@(posedge core_clk)
        disable iff (!nrst)
        !load_hi |=> out_reg[7:4] == $past(out_reg[7:4]))
        else $error("high nibble moved without strobe");

    chk_buf_write: assert property (@(posedge core_clk)
        disable iff (!nrst)
        wr_data |=> buf_reg == $past(reg_wdata))
        else $error("data write missed the buffer");

    chk_half_tick: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (tsel_lo == BWP_SRC_HALF) && load_lo |=> !half_reg ##1 half_reg)
        else $error("halved clock tick wrong");

    chk_timer_lo: assert property (@(posedge core_clk)
        disable iff (!nrst)
        (tsel_lo == BWP_SRC_TMR2) && $rose(timer_src[1]) |-> load_lo)
        else $error("timer edge missed");

    chk_pulse_once: assert property (@(posedge core_clk)
        disable iff (!nrst)
        load_hi && (tsel_hi != BWP_SRC_HALF) && !wr_ctl |=> !load_hi)
        else $error("timer strobe longer than a cycle");

    chk_od_low: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst |=> (pin_out & $past(drv_reg)) == 8'h00)
        else $error("open-drain pin drove high");

    chk_input_off: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst |=> (pin_oe & ~$past(dir_reg)) == 8'h00)
        else $error("input pin driven");

    chk_data_read: assert property (@(posedge core_clk)
        disable iff (!nrst)
        reg_rd && (reg_addr == `BWP_OFS_DATA)
        |=> reg_rdata == $past(port_view))
        else $error("data read mismatch");

    chk_wo_read: assert property (@(posedge core_clk)
        disable iff (!nrst)
        reg_rd && (reg_addr >= `BWP_OFS_CTL) |=> reg_rdata == 8'h00)
        else $error("write-only register read back");

    chk_sync_lat: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst ##1 nrst |=> pin_sync == $past(pin_in, 2))
        else $error("synchroniser latency wrong");

    chk_serial_tx: assert property (@(posedge core_clk)
        disable iff (!nrst)
        dir_reg[6] && fsel_reg[6] && !drv_reg[6]
        |=> pin_oe[6] && (pin_out[6] == $past(serial_a_transmit_data)))
        else $error("serial transmit not on pin");

    chk_rx_listen: assert property (@(posedge core_clk)
        disable iff (!nrst)
        fsel_reg[7] || fsel_reg[3] |=> !(pin_oe[7] && $past(fsel_reg[7]))
        && !(pin_oe[3] && $past(fsel_reg[3])))
        else $error("receive pin driven");

    chk_pwm_route: assert property (@(posedge core_clk)
        disable iff (!nrst)
        dir_reg[3] && pwm_reg[0] && !fsel_reg[3] && !drv_reg[3]
        |=> pin_out[3] == $past(alt_pwm_out_zero))
        else $error("pwm not routed to pin");

    chk_wo_regs: assert property (@(posedge core_clk)
        disable iff (!nrst)
        reg_rd && (reg_addr == `BWP_OFS_FSEL) ##1 1'b1
        |-> reg_rdata == 8'h00)
        else $error("function register read back");

    chk_rd_idle: assert property (@(posedge core_clk)
        disable iff (!nrst)
        nrst && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside its cycle");

endmodule : bwp_port

// file: testbench/bwp_pin_model.sv
// far side of the port: pins with a weak pull-up and an outside driver
// assumes the design splits each pin into out, oe and in
`timescale 1ns/1ps
module bwp_pin_model (
    // design side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // outside driver
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_oe,
    // resolved wire
    output logic [7:0] pin_lvl
);
    // ==============================================================
    // wire resolution
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i] && ext_oe[i]) begin
                pin_lvl[i] = (pin_out[i] == ext_val[i]) ? pin_out[i] : 1'bx;
            end else if (pin_oe[i]) begin
                pin_lvl[i] = pin_out[i];
            end else if (ext_oe[i]) begin
                pin_lvl[i] = ext_val[i];
            end else begin
                pin_lvl[i] = 1'b1;
            end
        end
    end
endmodule : bwp_pin_model

// file: testbench/tb_bwp_port.sv
// self-checking bench for the byte-wide buffered port
// assumes bwp_pin_model resolves the pins; timers driven here
`timescale 1ns/1ps
`include "bwp_regs.svh"
module tb_bwp_port;
    import bwp_pkg::*;
    typedef struct packed {
        logic [7:0] dir, drv, data, oe, out;
    } bwp_row_t;
    logic core_clk, nrst, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_out, pin_oe, pin_lvl;
    logic [7:0] ext_val, ext_oe, r, d, prev;
    logic [2:0] timer_src;
    logic [5:0] ser_in, ser_fb;
    logic [1:0] pwm_in;
    int fails, n_tests, cycles, lo;
    bwp_row_t rows[5] = '{
        '{8'hff, 8'h00, 8'ha5, 8'hff, 8'ha5},
        '{8'h0f, 8'h00, 8'hff, 8'h0f, 8'h0f},
        '{8'hff, 8'hff, 8'h5a, 8'ha5, 8'h00},
        '{8'hf0, 8'h0f, 8'h3c, 8'hf0, 8'h30},
        '{8'h3c, 8'h30, 8'h00, 8'h3c, 8'h00}};
    bwp_port dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .timer_src(timer_src),
        .serial_a_transmit_data(ser_in[5]),
        .serial_a_receive_clock(ser_in[4]),
        .serial_a_transmit_clock(ser_in[3]),
        .serial_a_receive_data(ser_fb[5]),
        .serial_a_rx_clock_in(ser_fb[4]), .serial_a_tx_clock_in(ser_fb[3]),
        .serial_b_transmit_data(ser_in[2]),
        .serial_b_receive_clock(ser_in[1]),
        .serial_b_transmit_clock(ser_in[0]),
        .serial_b_receive_data(ser_fb[2]),
        .serial_b_rx_clock_in(ser_fb[1]), .serial_b_tx_clock_in(ser_fb[0]),
        .alt_pwm_out_zero(pwm_in[0]), .alt_pwm_out_one(pwm_in[1]));
    bwp_pin_model far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_oe(ext_oe), .pin_lvl(pin_lvl));
    // ==============================================================
    // clock and timeout
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= 4000) begin
            fails++;
            report_and_stop();
        end
    end
    // ==============================================================
    // tasks
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_pins(input logic [7:0] eo, input logic [7:0] ev);
        chk(pin_oe, eo);
        chk(pin_out & pin_oe, ev & eo);
    endtask : chk_pins
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic pulse(input logic [2:0] m);
        @(posedge core_clk);
        timer_src <= m;
        repeat (2) @(posedge core_clk);
        timer_src <= 3'h0;
        tick(3);
    endtask : pulse
    // ==============================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {timer_src, ser_in, pwm_in, ext_val, ext_oe} = '0;
        repeat (5) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk_pins(8'h00, 8'h00);
        for (int o = 8'h4c; o <= 8'h50; o++) begin
            wr(8'(o), 8'h5a);
            rd(8'(o), r);
            chk(r, 8'h00);
        end
        wr(`BWP_OFS_FSEL, 8'h00);
        wr(`BWP_OFS_CTL, 8'h00);
        foreach (rows[i]) begin
            wr(`BWP_OFS_DIR, rows[i].dir);
            wr(`BWP_OFS_DRV, rows[i].drv);
            wr(`BWP_OFS_DATA, rows[i].data);
            tick(4);
            chk_pins(rows[i].oe, rows[i].out);
            rd(`BWP_OFS_DATA, r);
            chk(r, (rows[i].data & rows[i].dir) | ~rows[i].dir);
        end
        // value written while input waits for the direction change
        wr(`BWP_OFS_DRV, 8'h00);
        wr(`BWP_OFS_DIR, 8'h00);
        wr(`BWP_OFS_DATA, 8'h3c);
        tick(4);
        chk_pins(8'h00, 8'h00);
        wr(`BWP_OFS_DIR, 8'hff);
        tick(2);
        chk_pins(8'hff, 8'h3c);
        // each nibble on its own timer
        wr(`BWP_OFS_DATA, 8'h00);
        tick(4);
        prev = 8'h00;
        for (int i = 1; i <= 3; i++) begin
            lo = (i % 3) + 1;
            wr(`BWP_OFS_CTL, {2'b00, 2'(i), 2'b00, 2'(lo)});
            d = 8'(8'h11 * i);
            wr(`BWP_OFS_DATA, d);
            tick(6);
            chk_pins(8'hff, prev);
            pulse(3'(1 << (i - 1)));
            chk_pins(8'hff, {d[7:4], prev[3:0]});
            pulse(3'(1 << (lo - 1)));
            chk_pins(8'hff, d);
            prev = d;
        end
        // serial and pwm alternate outputs
        wr(`BWP_OFS_CTL, 8'h00);
        wr(`BWP_OFS_DATA, 8'h00);
        ser_in <= 6'h3f;
        wr(`BWP_OFS_FSEL, 8'h77);
        tick(4);
        chk_pins(8'hff, 8'h77);
        pwm_in <= 2'b11;
        wr(`BWP_OFS_PWM, 8'h03);
        tick(3);
        chk_pins(8'hff, 8'hff);
        wr(`BWP_OFS_PWM, 8'h00);
        // outside drive waits until pins 7 and 3 have let go
        wr(`BWP_OFS_FSEL, 8'h88);
        @(posedge core_clk);
        ext_oe <= 8'h88;
        ext_val <= 8'h80;
        tick(4);
        chk_pins(8'h77, 8'h00);
        chk({2'b00, ser_fb}, 8'h20);
        rd(`BWP_OFS_DATA, r);
        chk(r, 8'h80);
        // reset in mid-run clears direction and timing selects
        ext_oe <= 8'h00;
        wr(`BWP_OFS_FSEL, 8'h00);
        wr(`BWP_OFS_CTL, 8'h33);
        @(posedge core_clk);
        nrst <= 1'b0;
        tick(2);
        chk_pins(8'h00, 8'h00);
        @(posedge core_clk);
        nrst <= 1'b1;
        wr(`BWP_OFS_DIR, 8'hff);
        wr(`BWP_OFS_DATA, 8'hc3);
        tick(4);
        chk_pins(8'hff, 8'hc3);
        report_and_stop();
    end
endmodule : tb_bwp_port
